// ==== drcg_pkg.sv ====
// Purpose: Shared constants and types for the dynamic range controller gain curve.
// Assumes: Levels are signed values in sixteenths of a decibel, 0 meaning full scale.
// Notes: Register offsets are the codec control-register indices.
`default_nettype none
package drcg_pkg;
	// Level and register types.
	typedef logic signed [15:0] drcg_level_t;
	typedef logic signed [19:0] drcg_wide_t;
	typedef logic [15:0] drcg_word_t;
	typedef logic [7:0] drcg_addr_t;

	// Register offsets.
	localparam drcg_addr_t GAIN_CONTROL_ONE_OFS = 8'h1d;
	localparam drcg_addr_t KNEE_INPUT_LEVELS_OFS = 8'h20;
	localparam drcg_addr_t KNEE_OUTPUT_LEVELS_SLOPE_OFS = 8'h21;
	localparam drcg_addr_t GATE_AND_LOWER_SLOPES_OFS = 8'h23;

	// Field positions.
	localparam int GATE_REGION_ENABLE_POS = 8;
	localparam int SECOND_KNEE_INPUT_LSB = 8;
	localparam int FIRST_KNEE_INPUT_LSB = 2;
	localparam int SECOND_KNEE_OUTPUT_ENABLE_POS = 13;
	localparam int SECOND_KNEE_OUTPUT_LSB = 8;
	localparam int FIRST_KNEE_OUTPUT_LSB = 3;
	localparam int UPPER_COMPRESSION_LSB = 0;
	localparam int GATE_EXPANSION_LSB = 8;
	localparam int LOWER_COMPRESSION_LSB = 5;

	// Values after reset.
	localparam logic GATE_REGION_ENABLE_RST = 1'b0;
	localparam logic [4:0] SECOND_KNEE_INPUT_RST = 5'h00;
	localparam logic [5:0] FIRST_KNEE_INPUT_RST = 6'h00;
	localparam logic SECOND_KNEE_OUTPUT_ENABLE_RST = 1'b0;
	localparam logic [4:0] SECOND_KNEE_OUTPUT_RST = 5'h00;
	localparam logic [4:0] FIRST_KNEE_OUTPUT_RST = 5'h00;
	localparam logic [2:0] UPPER_COMPRESSION_RST = 3'h3;
	localparam logic [1:0] GATE_EXPANSION_RST = 2'h0;
	localparam logic [2:0] LOWER_COMPRESSION_RST = 3'h0;

	// Level decoding, in sixteenths of a decibel.
	localparam drcg_wide_t FINE_STEP = 20'sd12;
	localparam drcg_wide_t COARSE_STEP = 20'sd24;
	localparam drcg_wide_t SECOND_KNEE_INPUT_TOP = -20'sd576;
	localparam drcg_wide_t SECOND_KNEE_OUTPUT_TOP = -20'sd480;
	localparam logic [5:0] FIRST_KNEE_INPUT_MAX = 6'h3c;
	localparam logic [4:0] FIRST_KNEE_OUTPUT_MAX = 5'h1e;

	// Slope codes that hold the output fixed.
	localparam logic [2:0] UPPER_SLOPE_ZERO = 3'h5;
	localparam logic [2:0] LOWER_SLOPE_ZERO = 3'h4;

	// Cycles from an accepted input level to its output level.
	localparam int CURVE_LATENCY = 2;
endpackage
`default_nettype wire

// ==== drcg_gain_curve.sv ====
// Purpose: Static gain curve of the dynamic range controller, mapping input level to target output level.
// Assumes: Input levels arrive on the core clock with a valid strobe; register writes come from the control port.
// Notes: Two-cycle latency; the curve uses register values as they stand when the level is computed.
// Reserved slope codes act as slope zero, and reserved knee codes as the lowest documented level.
//
// How it works
// RULE1 - Above the gate region the curve has two compression regions split by one programmable knee.
// RULE2 - In the record path software keeps the input high-pass filter on so no DC offset reaches this block.
// RULE3 - A compression slope of one keeps gain constant, below one shrinks output change, zero holds output fixed.
// RULE4 - With the gate on, levels below the second knee follow the expansion slope.
// RULE5 - With the second output knee on, the curve drops vertically to its output level at the second knee input.
// RULE6 - With the gate off, the second knee and expansion settings are ignored and the lower slope runs to the bottom.
// RULE7 - With the second output knee off, the second knee sits on the lower compression line with no drop.
// RULE8 - The full-scale output level is the first knee output minus the first knee input times the upper slope.
// RULE9 - The gate enable is bit 8 of the first control register and resets to zero.
// RULE10 - The second knee input field decodes code zero as -36 dB falling 1.5 dB per code, used only with the gate on.
// RULE11 - The first knee input field decodes zero as 0 dB falling 0.75 dB per code to -45 dB, higher codes reserved.
// RULE12 - The second knee output field decodes -30 dB down in 1.5 dB steps and acts only with its enable bit set.
// RULE13 - The first knee output field decodes zero as 0 dB falling 0.75 dB per code to -22.5 dB, the top code reserved.
// RULE14 - The upper slope field maps codes 0 to 5 onto 1, 1/2, 1/4, 1/8, 1/16 and 0 and resets to 3.
// RULE15 - The lower slope field maps codes 0 to 4 onto 1, 1/2, 1/4, 1/8 and 0 and resets to 0.
// RULE16 - The expansion slope field maps codes 0 to 3 onto 1, 2, 4 and 8 and resets to 0.
`timescale 1ns/100ps
`default_nettype none
module drcg_gain_curve (
	// Clock and reset.
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// Control register port.
	input wire logic REG_WR,
	input wire drcg_pkg::drcg_addr_t REG_ADDR,
	input wire drcg_pkg::drcg_word_t REG_WDATA,
	output drcg_pkg::drcg_word_t REG_RDATA,
	// Level stream in.
	input wire logic LEVEL_IN_VALID,
	input wire drcg_pkg::drcg_level_t LEVEL_IN,
	// Level stream out.
	output logic LEVEL_OUT_VALID,
	output drcg_pkg::drcg_level_t LEVEL_OUT,
	// Derived full-scale output level.
	output drcg_pkg::drcg_level_t FULL_SCALE_LEVEL
);
	import drcg_pkg::*;

	logic gate_region_enable;
	logic [4:0] second_knee_input_level;
	logic [5:0] first_knee_input_level;
	logic second_knee_output_enable;
	logic [4:0] second_knee_output_level;
	logic [4:0] first_knee_output_level;
	logic [2:0] upper_compression_slope;
	logic [1:0] gate_expansion_slope;
	logic [2:0] lower_compression_slope;

	logic level_valid;
	drcg_level_t level_held;
	drcg_wide_t knee1_in;
	drcg_wide_t knee1_out;
	drcg_wide_t knee2_in;
	drcg_wide_t knee2_out;
	drcg_wide_t next_level_out;
	drcg_wide_t next_full_scale;

	// Level of a code counted down from a top value in equal steps.
	// Every level sits at or below full scale, so codes only ever step downward.
	function automatic drcg_wide_t step_level(input drcg_wide_t top, input logic [5:0] code, input drcg_wide_t step);
		drcg_wide_t wide_code;
		wide_code = drcg_wide_t'({14'h0, code});
		return drcg_wide_t'(top - wide_code * step);
	endfunction

	// First knee input level; reserved codes are held at the lowest documented level.
	function automatic drcg_wide_t knee1_input_level(input logic [5:0] code);
		logic [5:0] legal;
		legal = code;
		if (code > FIRST_KNEE_INPUT_MAX) begin
			legal = FIRST_KNEE_INPUT_MAX;
		end
		return step_level('0, legal, FINE_STEP);
	endfunction

	// First knee output level; the reserved top code is held at the lowest documented level.
	function automatic drcg_wide_t knee1_output_level(input logic [4:0] code);
		logic [4:0] legal;
		legal = code;
		if (code > FIRST_KNEE_OUTPUT_MAX) begin
			legal = FIRST_KNEE_OUTPUT_MAX;
		end
		return step_level('0, {1'b0, legal}, FINE_STEP);
	endfunction

	// Second knee input level; every code is legal.
	function automatic drcg_wide_t knee2_input_level(input logic [4:0] code);
		return step_level(SECOND_KNEE_INPUT_TOP, {1'b0, code}, COARSE_STEP);
	endfunction

	// Second knee output level; every code is legal.
	function automatic drcg_wide_t knee2_output_level(input logic [4:0] code);
		return step_level(SECOND_KNEE_OUTPUT_TOP, {1'b0, code}, COARSE_STEP);
	endfunction

	// Expansion below the second knee; the result can fall far below the port range, so callers saturate.
	function automatic drcg_wide_t expand_slope(input drcg_wide_t diff, input logic [1:0] code);
		drcg_wide_t result;
		result = diff;
		// RULE16 expansion slope decode
		unique case (code)
			2'h0: begin
				result = diff;
			end
			2'h1: begin
				result = diff <<< 1;
			end
			2'h2: begin
				result = diff <<< 2;
			end
			2'h3: begin
				result = diff <<< 3;
			end
		endcase
		return result;
	endfunction

	// Upper region slope applied to a level difference.
	// The zero code and the reserved codes both give a flat region.
	function automatic drcg_wide_t upper_slope(input drcg_wide_t diff, input logic [2:0] code);
		drcg_wide_t result;
		result = '0;
		// RULE14 upper slope decode
		// RULE3 slope of one or less
		unique case (code)
			3'h0: begin
				result = diff;
			end
			3'h1: begin
				result = diff >>> 1;
			end
			3'h2: begin
				result = diff >>> 2;
			end
			3'h3: begin
				result = diff >>> 3;
			end
			3'h4: begin
				result = diff >>> 4;
			end
			UPPER_SLOPE_ZERO: begin
				result = '0;
			end
			default: begin
				result = '0;
			end
		endcase
		return result;
	endfunction

	// Lower region slope applied to a level difference.
	// The zero code and the reserved codes both give a flat region.
	function automatic drcg_wide_t lower_slope(input drcg_wide_t diff, input logic [2:0] code);
		drcg_wide_t result;
		result = '0;
		// RULE15 lower slope decode
		// RULE3 slope of one or less
		unique case (code)
			3'h0: begin
				result = diff;
			end
			3'h1: begin
				result = diff >>> 1;
			end
			3'h2: begin
				result = diff >>> 2;
			end
			3'h3: begin
				result = diff >>> 3;
			end
			LOWER_SLOPE_ZERO: begin
				result = '0;
			end
			default: begin
				result = '0;
			end
		endcase
		return result;
	endfunction

	// Limit a wide level to the port range.
	// Deep expansion can fall far below the port range, so results saturate instead of wrapping.
	function automatic drcg_level_t clamp_level(input drcg_wide_t value);
		drcg_level_t result;
		if (value > 20'sd32767) begin
			result = 16'sh7fff;
		end else if (value < -20'sd32768) begin
			result = -16'sh8000;
		end else begin
			result = drcg_level_t'(value);
		end
		return result;
	endfunction

	// Register writes, one process per register; writes to other offsets are dropped.
	// RULE9 gate enable bit
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			gate_region_enable <= GATE_REGION_ENABLE_RST;
		end else if (REG_WR && (REG_ADDR == GAIN_CONTROL_ONE_OFS)) begin
			gate_region_enable <= REG_WDATA[GATE_REGION_ENABLE_POS];
		end
	end

	// Knee input levels.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			second_knee_input_level <= SECOND_KNEE_INPUT_RST;
			first_knee_input_level <= FIRST_KNEE_INPUT_RST;
		end else if (REG_WR && (REG_ADDR == KNEE_INPUT_LEVELS_OFS)) begin
			second_knee_input_level <= REG_WDATA[SECOND_KNEE_INPUT_LSB +: 5];
			first_knee_input_level <= REG_WDATA[FIRST_KNEE_INPUT_LSB +: 6];
		end
	end

	// Knee output levels and upper slope.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			second_knee_output_enable <= SECOND_KNEE_OUTPUT_ENABLE_RST;
			second_knee_output_level <= SECOND_KNEE_OUTPUT_RST;
			first_knee_output_level <= FIRST_KNEE_OUTPUT_RST;
			upper_compression_slope <= UPPER_COMPRESSION_RST;
		end else if (REG_WR && (REG_ADDR == KNEE_OUTPUT_LEVELS_SLOPE_OFS)) begin
			second_knee_output_enable <= REG_WDATA[SECOND_KNEE_OUTPUT_ENABLE_POS];
			second_knee_output_level <= REG_WDATA[SECOND_KNEE_OUTPUT_LSB +: 5];
			first_knee_output_level <= REG_WDATA[FIRST_KNEE_OUTPUT_LSB +: 5];
			upper_compression_slope <= REG_WDATA[UPPER_COMPRESSION_LSB +: 3];
		end
	end

	// Expansion and lower slopes.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			gate_expansion_slope <= GATE_EXPANSION_RST;
			lower_compression_slope <= LOWER_COMPRESSION_RST;
		end else if (REG_WR && (REG_ADDR == GATE_AND_LOWER_SLOPES_OFS)) begin
			gate_expansion_slope <= REG_WDATA[GATE_EXPANSION_LSB +: 2];
			lower_compression_slope <= REG_WDATA[LOWER_COMPRESSION_LSB +: 3];
		end
	end

	// Register read-back; unmapped offsets and reserved bits read as zero.
	// The word is registered, so it shows the offset presented one cycle before.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			REG_RDATA <= '0;
		end else begin
			REG_RDATA <= '0;
			unique case (REG_ADDR)
				GAIN_CONTROL_ONE_OFS: begin
					REG_RDATA[GATE_REGION_ENABLE_POS] <= gate_region_enable;
				end
				KNEE_INPUT_LEVELS_OFS: begin
					REG_RDATA[SECOND_KNEE_INPUT_LSB +: 5] <= second_knee_input_level;
					REG_RDATA[FIRST_KNEE_INPUT_LSB +: 6] <= first_knee_input_level;
				end
				KNEE_OUTPUT_LEVELS_SLOPE_OFS: begin
					REG_RDATA[SECOND_KNEE_OUTPUT_ENABLE_POS] <= second_knee_output_enable;
					REG_RDATA[SECOND_KNEE_OUTPUT_LSB +: 5] <= second_knee_output_level;
					REG_RDATA[FIRST_KNEE_OUTPUT_LSB +: 5] <= first_knee_output_level;
					REG_RDATA[UPPER_COMPRESSION_LSB +: 3] <= upper_compression_slope;
				end
				GATE_AND_LOWER_SLOPES_OFS: begin
					REG_RDATA[GATE_EXPANSION_LSB +: 2] <= gate_expansion_slope;
					REG_RDATA[LOWER_COMPRESSION_LSB +: 3] <= lower_compression_slope;
				end
				default: begin
				end
			endcase
		end
	end

	// Knee points, decoded from the stored fields.
	always_comb begin
		// RULE11 first knee input decode
		knee1_in = knee1_input_level(first_knee_input_level);
		// RULE13 first knee output decode
		knee1_out = knee1_output_level(first_knee_output_level);
		// RULE10 second knee input decode
		knee2_in = knee2_input_level(second_knee_input_level);
		// RULE7 knee on lower line
		knee2_out = knee1_out + lower_slope(knee2_in - knee1_in, lower_compression_slope);
		// RULE12 second knee output decode
		// RULE5 vertical drop
		if (second_knee_output_enable) begin
			knee2_out = knee2_output_level(second_knee_output_level);
		end
	end

	// Curve evaluation on the held input level.
	// A level exactly on the first knee takes the upper region, one exactly on the second knee the lower region.
	always_comb begin
		drcg_wide_t x;
		x = drcg_wide_t'(level_held);
		// RULE1 knee splits regions
		if (x >= knee1_in) begin
			next_level_out = knee1_out + upper_slope(x - knee1_in, upper_compression_slope);
		end else if (gate_region_enable && (x < knee2_in)) begin
			// RULE4 expansion below knee
			// RULE16 expansion slope decode
			next_level_out = knee2_out + expand_slope(x - knee2_in, gate_expansion_slope);
		end else begin
			// RULE6 gate off lower slope
			next_level_out = knee1_out + lower_slope(x - knee1_in, lower_compression_slope);
		end
	end

	// RULE8 full scale level
	assign next_full_scale = knee1_out + upper_slope(-knee1_in, upper_compression_slope);

	// Input capture stage.
	// Only the strobe moves the held level, so the output keeps the last result between samples.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			level_valid <= 1'b0;
			level_held <= '0;
		end else begin
			level_valid <= LEVEL_IN_VALID;
			if (LEVEL_IN_VALID) begin
				level_held <= LEVEL_IN;
			end
		end
	end

	// Output stage.
	// The full-scale level is refreshed every cycle, so it follows a register write two cycles later without samples.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			LEVEL_OUT_VALID <= 1'b0;
			LEVEL_OUT <= '0;
			FULL_SCALE_LEVEL <= '0;
		end else begin
			LEVEL_OUT_VALID <= level_valid;
			FULL_SCALE_LEVEL <= clamp_level(next_full_scale);
			if (level_valid) begin
				LEVEL_OUT <= clamp_level(next_level_out);
			end
		end
	end
endmodule
`default_nettype wire

// ==== drcg_gain_curve_properties.sv ====
// Purpose: Port checks for the gain curve.
// Assumes: One core clock, active low reset.
// Notes: Bound from the bench top file.
`timescale 1ns/100ps
`default_nettype none
module drcg_gain_curve_properties (
	// Clock and reset.
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// Register port.
	input wire logic REG_WR,
	input wire drcg_pkg::drcg_addr_t REG_ADDR,
	input wire drcg_pkg::drcg_word_t REG_WDATA,
	input wire drcg_pkg::drcg_word_t REG_RDATA,
	// Level streams.
	input wire logic LEVEL_IN_VALID,
	input wire drcg_pkg::drcg_level_t LEVEL_IN,
	input wire logic LEVEL_OUT_VALID,
	input wire drcg_pkg::drcg_level_t LEVEL_OUT,
	input wire drcg_pkg::drcg_level_t FULL_SCALE_LEVEL
);
	import drcg_pkg::*;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	sequence s_wr5; REG_WR && REG_ADDR == 8'h21 ##1 !REG_WR && REG_ADDR == 8'h21; endsequence
	property p_lat; LEVEL_IN_VALID |-> ##2 LEVEL_OUT_VALID; endproperty
	a_lat: assert property (p_lat) else $error("late strobe");
	property p_quiet; !LEVEL_IN_VALID |-> ##2 !LEVEL_OUT_VALID; endproperty
	a_quiet: assert property (p_quiet) else $error("stray strobe");
	property p_hold; !LEVEL_OUT_VALID |-> $stable(LEVEL_OUT); endproperty
	a_hold: assert property (p_hold) else $error("level moved");
	property p_wr5; s_wr5 |=> REG_RDATA == ($past(REG_WDATA, 2) & 16'h3fff); endproperty
	a_wr5: assert property (p_wr5) else $error("readback");
	property p_flat; REG_WR && REG_ADDR == 8'h21 && REG_WDATA[2:0] == 3'h5 && REG_WDATA[7:3] != 5'h1f
		|-> ##2 int'(FULL_SCALE_LEVEL) == -12 * int'($past(REG_WDATA[7:3], 2)); endproperty
	a_flat: assert property (p_flat) else $error("full scale");
	property p_still; !REG_WR |-> ##2 $stable(FULL_SCALE_LEVEL); endproperty
	a_still: assert property (p_still) else $error("full scale moved");
	property p_rd1; REG_ADDR == 8'h1d |=> (REG_RDATA & 16'hfeff) == 16'h0000; endproperty
	a_rd1: assert property (p_rd1) else $error("reg 1d bits");
	property p_rd7; REG_ADDR == 8'h23 |=> (REG_RDATA & 16'hfc1f) == 16'h0000; endproperty
	a_rd7: assert property (p_rd7) else $error("reg 23 bits");
endmodule
`default_nettype wire

// ==== drcg_level_source.sv ====
// Purpose: Sample path model feeding levels.
// Assumes: Levels carry no DC offset.
// Notes: Stale data is inverted between samples.
`timescale 1ns/100ps
`default_nettype none
module drcg_level_source (
	// Clock.
	input wire logic clk,
	// Level stream.
	output var logic valid,
	output var drcg_pkg::drcg_level_t level
);
	import drcg_pkg::*;
	initial begin
		valid = 1'b0;
		level = 16'h0000;
	end
	task automatic send(input drcg_level_t x);
		@(posedge clk);
		valid <= 1'b1;
		level <= x;
		@(posedge clk);
		valid <= 1'b0;
		level <= ~x;
	endtask
endmodule
`default_nettype wire

// ==== tb_dynamic_range_gain_curve.sv ====
// Purpose: Self-checking bench for the gain curve.
// Assumes: Levels in sixteenths of a decibel.
// Notes: Expected levels are worked out by hand.
`timescale 1ns/100ps
`default_nettype none
module tb_dynamic_range_gain_curve;
	import drcg_pkg::*;
	logic clk, rstn, wr_en, iv, ov;
	drcg_addr_t addr;
	drcg_word_t wdata, rdata;
	drcg_level_t il, ol, fs;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int ho[6] = '{64, -16, -56, -76, -86, -96};
	int hf[6] = '{96, 0, -48, -72, -84, -96};
	int lo[5] = '{-256, -176, -136, -116, -96};
	int xo[4] = '{-368, -400, -464, -592};
	drcg_gain_curve dut (.CORE_CLK(clk), .RSTN(rstn), .REG_WR(wr_en), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_RDATA(rdata), .LEVEL_IN_VALID(iv), .LEVEL_IN(il), .LEVEL_OUT_VALID(ov), .LEVEL_OUT(ol),
		.FULL_SCALE_LEVEL(fs));
	drcg_level_source src (.clk(clk), .valid(iv), .level(il));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(drcg_addr_t a, drcg_word_t d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
	endtask
	task automatic rd(drcg_addr_t a, drcg_word_t e);
		@(posedge clk);
		wr_en <= 1'b0;
		addr <= a;
		@(posedge clk);
		#1 chk("rdata", e, rdata);
	endtask
	task automatic run(drcg_word_t c1, c4, c5, c7, drcg_level_t x, int e, int f);
		wr(8'h1d, c1);
		wr(8'h20, c4);
		wr(8'h21, c5);
		wr(8'h23, c7);
		@(posedge clk);
		wr_en <= 1'b0;
		src.send(x);
		@(posedge clk);
		#1 chk("level valid", 16'h0001, {15'h0000, ov});
		chk("level", e[15:0], ol);
		chk("full scale", f[15:0], fs);
	endtask
	initial begin
		rstn = 1'b0;
		wr_en = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rd(8'h1d, 16'h0000);
		rd(8'h20, 16'h0000);
		rd(8'h21, 16'h0003);
		rd(8'h23, 16'h0000);
		$display("test reset done");
		wr(8'h1d, 16'hffff);
		wr(8'h20, 16'hffff);
		wr(8'h23, 16'hffff);
		wr(8'h22, 16'hffff);
		wr(8'h21, 16'hffff);
		rd(8'h21, 16'h3fff);
		rd(8'h1d, 16'h0100);
		rd(8'h20, 16'h1ffc);
		rd(8'h23, 16'h03e0);
		rd(8'h22, 16'h0000);
		$display("test access done");
		run(16'h0000, 16'h0000, 16'h0003, 16'h0000, -16'sd160, -160, 0);
		for (int c = 0; c < 6; c++) begin
			run(16'h0000, 16'h0040, 16'h0040 | 16'(c), 16'h0000, -16'sd32, ho[c], hf[c]);
		end
		for (int c = 0; c < 5; c++) begin
			run(16'h0000, 16'h0040, 16'h0040, 16'h0300 | 16'(c << 5), -16'sd352, lo[c], 96);
		end
		$display("test slopes done");
		run(16'h0000, 16'h0440, 16'h0040, 16'h0120, -16'sd704, -352, 96);
		run(16'h0100, 16'h0440, 16'h0040, 16'h0120, -16'sd704, -400, 96);
		run(16'h0100, 16'h0440, 16'h2240, 16'h0120, -16'sd704, -592, 96);
		run(16'h0100, 16'h0440, 16'h2240, 16'h0120, -16'sd672, -336, 96);
		run(16'h0100, 16'h0440, 16'h2240, 16'h0120, -16'sd673, -530, 96);
		run(16'h0100, 16'h0440, 16'h2240, 16'h0120, -16'sd192, -96, 96);
		run(16'h0100, 16'h0440, 16'h2240, 16'h0120, -16'sd193, -97, 96);
		run(16'h0100, 16'h1f40, 16'h0040, 16'h0120, -16'sd1352, -724, 96);
		for (int c = 0; c < 4; c++) begin
			run(16'h0100, 16'h0440, 16'h0040, 16'h0020 | 16'(c << 8), -16'sd704, xo[c], 96);
		end
		$display("test gate done");
		run(16'h0000, 16'h00f0, 16'h0000, 16'h0000, 16'sd0, 720, 720);
		run(16'h0000, 16'h00fc, 16'h0000, 16'h0000, 16'sd0, 720, 720);
		run(16'h0000, 16'h0000, 16'h00f5, 16'h0000, 16'sd0, -360, -360);
		run(16'h0000, 16'h0000, 16'h00fd, 16'h0000, 16'sd0, -360, -360);
		$display("test knees done");
		wrap_up();
	end
endmodule
bind drcg_gain_curve drcg_gain_curve_properties u_props (.CORE_CLK, .RSTN, .REG_WR, .REG_ADDR, .REG_WDATA,
	.REG_RDATA, .LEVEL_IN_VALID, .LEVEL_IN, .LEVEL_OUT_VALID, .LEVEL_OUT, .FULL_SCALE_LEVEL);
`default_nettype wire
